//--- kwdt_pkg.sv
package kwdt_pkg;
  localparam int KWDT_AW = 4;
  // register byte offsets
  localparam logic [KWDT_AW-1:0] KWDT_CTRL_OFS = 4'h0;
  localparam logic [KWDT_AW-1:0] KWDT_FLAG_OFS = 4'h4;
  localparam logic [KWDT_AW-1:0] KWDT_IST_OFS = 4'h8;
  localparam logic [KWDT_AW-1:0] KWDT_IMSK_OFS = 4'hC;
  // control fields
  localparam int KWDT_KEY_LSB = 3;
  localparam int KWDT_KEY_W = 5;
  localparam int KWDT_SEL_W = 3;
  localparam logic [4:0] KWDT_KEY_DIS = 5'h15;
  localparam logic [4:0] KWDT_KEY_EN = 5'h0A;
  localparam logic [7:0] KWDT_CTRL_RST = 8'h53;
  // flag bit positions
  localparam int KWDT_KEYRST_BIT = 0;
  localparam int KWDT_EXPIRY_BIT = 1;
  localparam int KWDT_PDOWN_BIT = 2;
  // interrupt status bits
  localparam int KWDT_IRQ_EXP = 0;
  localparam int KWDT_IRQ_KEY = 1;
  localparam int KWDT_IRQ_W = 2;
  // count width for 2^18 periods
  localparam int KWDT_CNT_W = 19;
  // low-speed oscillator and its tick derived from the 8 ns clock
  localparam int KWDT_CLK_KHZ = 125000;
  localparam int KWDT_LSO_KHZ = 32;
  localparam int KWDT_LSO_DIV = KWDT_CLK_KHZ / KWDT_LSO_KHZ;
  localparam int KWDT_DIV_W = 12;
  // software reset delay in low-speed periods
  localparam int KWDT_SRST_LSO = 8;
  localparam logic [1:0] KWDT_RESP_OK = 2'h0;
  localparam logic [1:0] KWDT_RESP_ERR = 2'h2;
endpackage

//--- kwdt_lso_tick.sv
`timescale 1ns/1ps
module kwdt_lso_tick
  import kwdt_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic sys_rst_in, // async reset, high
  output logic tick_out // one-cycle low-speed tick
);
  logic [KWDT_DIV_W-1:0] div_q;

  // models the 32 kHz low-speed internal oscillator as a tick
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      div_q <= '0;
      tick_out <= 1'b0;
    end
    else if (div_q == KWDT_DIV_W'(KWDT_LSO_DIV - 1))
    begin
      div_q <= '0;
      tick_out <= 1'b1; // R1
    end
    else
    begin
      div_q <= div_q + 1'b1;
      tick_out <= 1'b0;
    end
  end
endmodule

//--- kwdt_sync.sv
`timescale 1ns/1ps
module kwdt_sync
  import kwdt_pkg::*;
#(
  parameter int W = 3
)
(
  input wire logic ref_clk_in, // system clock
  input wire logic sys_rst_in, // async reset, high
  input wire logic [W-1:0] async_in, // pins from outside
  output logic [W-1:0] sync_out // synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

//--- kwdt_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: the counter runs on a 32 kHz low-speed tick, divided by 2^8 to 2^18.
// R2: select 0..7 gives 2^8,2^10,2^12,2^14,2^15,2^16,2^17,2^18 periods.
// R3: key 10101B disables the watchdog and key 01010B enables it.
// R4: any other key requests a delayed reset and sets the key reset flag.
// R5: the key reset flag is set only by a key reset and cleared by writing 0.
// R6: after reset the key is 01010B and the select is 011.
// R7: overflow when running requests a full reset and sets expiry.
// R8: overflow in sleep or idle sets expiry and resets only pc and sp.
// R9: the count clears on key reset, the clear instruction, or halt.
// R10: flag register bits 7 to 4 always read as zero.
// R11: halt clears the count; it runs on only if enabled.
// R12: power down flag clears on power-up or clear, sets on halt.
// R13: the key reset waits a set count of low-speed periods then pulses.
module kwdt_top
  import kwdt_pkg::*;
(
  input wire logic ref_clk_in, // 125 MHz clock
  input wire logic sys_rst_in, // async reset, high
  input wire logic [KWDT_AW-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [KWDT_AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic watchdog_clear_instr_in, // clear instruction executed
  input wire logic halt_in, // halt instruction executed
  input wire logic sleep_in, // core in sleep or idle
  output logic sys_rst_req_out, // full reset pulse
  output logic pc_sp_rst_out, // pc and sp reset pulse
  output logic irq_out // interrupt level
);
  ////////////////////////////////////////////////////////////////////////////
  logic lso_tick;
  logic [2:0] cpu_s;
  logic clr_s, halt_s, sleep_s, clr_p, halt_p;
  logic clr_d1_q, halt_d1_q;
  logic [7:0] ctrl_q;
  logic keyrst_q, expiry_q, pdown_q;
  logic [KWDT_CNT_W-1:0] cnt_q;
  logic [3:0] srst_cnt_q;
  logic srst_busy_q;
  logic [KWDT_IRQ_W-1:0] ist_q, imsk_q;
  logic aw_hold_q, w_hold_q;
  logic [KWDT_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go, ovf, key_bad, key_en, key_fire;
  logic [4:0] key;
  logic [KWDT_IRQ_W-1:0] ev;

  kwdt_lso_tick u_tick (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .tick_out(lso_tick)
  );

  kwdt_sync #(.W(3)) u_sync (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({watchdog_clear_instr_in, halt_in, sleep_in}),
    .sync_out(cpu_s)
  );

  assign clr_s = cpu_s[2];
  assign halt_s = cpu_s[1];
  assign sleep_s = cpu_s[0];

  // overflow count for each select code
  function automatic logic [KWDT_CNT_W-1:0] limit_of(input logic [2:0] sel);
    logic [4:0] sh;
    sh = 5'h0;
    unique case (sel)
      3'h0: sh = 5'h08; // R2
      3'h1: sh = 5'h0A;
      3'h2: sh = 5'h0C;
      3'h3: sh = 5'h0E;
      3'h4: sh = 5'h0F;
      3'h5: sh = 5'h10;
      3'h6: sh = 5'h11;
      3'h7: sh = 5'h12;
    endcase
    return KWDT_CNT_W'(1) << sh;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // edge detect on synchronised instruction strobes
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      clr_d1_q <= 1'b0;
      halt_d1_q <= 1'b0;
    end
    else
    begin
      clr_d1_q <= clr_s;
      halt_d1_q <= halt_s;
    end
  end

  assign clr_p = clr_s & ~clr_d1_q;
  assign halt_p = halt_s & ~halt_d1_q;
  assign key = ctrl_q[KWDT_KEY_LSB +: KWDT_KEY_W];
  assign key_en = (key == KWDT_KEY_EN); // R3
  assign key_bad = (key != KWDT_KEY_EN) && (key != KWDT_KEY_DIS); // R4
  assign key_fire = key_bad & ~srst_busy_q;
  assign ovf = key_en && lso_tick
    && (cnt_q == limit_of(ctrl_q[KWDT_SEL_W-1:0]) - 1'b1);
  assign ev = {key_fire, ovf};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= KWDT_RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == KWDT_CTRL_OFS ||
          awaddr_q == KWDT_FLAG_OFS || awaddr_q == KWDT_IST_OFS ||
          awaddr_q == KWDT_IMSK_OFS) ? KWDT_RESP_OK : KWDT_RESP_ERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;

  ////////////////////////////////////////////////////////////////////////////
  // read channel, one cycle after address
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= KWDT_RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= KWDT_RESP_OK;
      unique case (s_axi_araddr)
        KWDT_CTRL_OFS: s_axi_rdata <= {24'h0, ctrl_q};
        KWDT_FLAG_OFS: s_axi_rdata <= {29'h0, pdown_q, expiry_q,
          keyrst_q}; // R10
        KWDT_IST_OFS: s_axi_rdata <= {30'h0, ist_q};
        KWDT_IMSK_OFS: s_axi_rdata <= {30'h0, imsk_q};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= KWDT_RESP_ERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  assign s_axi_arready = !s_axi_rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      ctrl_q <= KWDT_CTRL_RST; // R6
    else if (wr_go && awaddr_q == KWDT_CTRL_OFS && wstrb_q[0])
      ctrl_q <= wdata_q[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog count
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      cnt_q <= '0;
    else if (key_bad || clr_p || halt_p || ovf)
      cnt_q <= '0; // R9 R11
    else if (key_en && lso_tick)
      cnt_q <= cnt_q + 1'b1; // R1
  end

  ////////////////////////////////////////////////////////////////////////////
  // delayed key reset
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      srst_busy_q <= 1'b0;
      srst_cnt_q <= '0;
    end
    else if (key_fire)
    begin
      srst_busy_q <= 1'b1;
      srst_cnt_q <= '0;
    end
    else if (srst_busy_q && lso_tick)
    begin
      if (srst_cnt_q == 4'(KWDT_SRST_LSO - 1))
        srst_busy_q <= 1'b0; // R13
      else
        srst_cnt_q <= srst_cnt_q + 1'b1;
    end
  end

  // reset pulses
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sys_rst_req_out <= 1'b0;
      pc_sp_rst_out <= 1'b0;
    end
    else
    begin
      sys_rst_req_out <= (ovf && !sleep_s) || (srst_busy_q && lso_tick &&
        srst_cnt_q == 4'(KWDT_SRST_LSO - 1)); // R4 R7 R13
      pc_sp_rst_out <= ovf && sleep_s; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset cause flags: set wins over clear
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      keyrst_q <= 1'b0;
      expiry_q <= 1'b0;
      pdown_q <= 1'b0; // R12
    end
    else
    begin
      if (key_fire)
        keyrst_q <= 1'b1; // R4 R5
      else if (wr_go && awaddr_q == KWDT_FLAG_OFS && wstrb_q[0] &&
        !wdata_q[KWDT_KEYRST_BIT])
        keyrst_q <= 1'b0; // R5
      if (ovf)
        expiry_q <= 1'b1; // R7 R8
      else if (halt_p || clr_p)
        expiry_q <= 1'b0;
      else if (wr_go && awaddr_q == KWDT_FLAG_OFS && wstrb_q[0] &&
        !wdata_q[KWDT_EXPIRY_BIT])
        expiry_q <= 1'b0;
      if (halt_p)
        pdown_q <= 1'b1; // R12
      else if (clr_p)
        pdown_q <= 1'b0; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, set wins
  genvar gi;
  generate
    for (gi = 0; gi < KWDT_IRQ_W; gi++)
    begin : g_ist
      always_ff @(posedge ref_clk_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
          ist_q[gi] <= 1'b0;
        else if (ev[gi])
          ist_q[gi] <= 1'b1;
        else if (wr_go && awaddr_q == KWDT_IST_OFS && wstrb_q[0] &&
          wdata_q[gi])
          ist_q[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      imsk_q <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      if (wr_go && awaddr_q == KWDT_IMSK_OFS && wstrb_q[0])
        imsk_q <= wdata_q[KWDT_IRQ_W-1:0];
      irq_out <= |(ist_q & imsk_q);
    end
  end
endmodule

//--- kwdt_properties.sv
`timescale 1ns/1ps
module kwdt_properties
  import kwdt_pkg::*;
(
  input wire logic ref_clk_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic [KWDT_AW-1:0] s_axi_araddr, // ar addr
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic sys_rst_req_out, // reset pulse
  input wire logic pc_sp_rst_out // pc sp pulse
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  logic rd_flag_q;
  // remembers whether the pending read targets the flag register
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      rd_flag_q <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready)
      rd_flag_q <= (s_axi_araddr == KWDT_FLAG_OFS);
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rst_quiet;
    !sys_rst_req_out [*8];
  endsequence
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  chk_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("no write answer");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no read answer");
  chk_rdata_upper: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h0) else $error("upper data set");
  chk_flag_upper: assert property (
    s_axi_rvalid && rd_flag_q |-> s_axi_rdata[7:4] == 4'h0)
    else $error("flag bits 7:4 set");
  chk_rst_pulse: assert property (sys_rst_req_out |=> s_rst_quiet)
    else $error("reset pulse too long");
  chk_pcsp_pulse: assert property (pc_sp_rst_out |=> !pc_sp_rst_out)
    else $error("pc sp pulse too long");
endmodule
////////////////////////////////////////////////////////////////////////////
bind kwdt_top kwdt_properties u_kwdt_properties (.ref_clk_in, .sys_rst_in,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .sys_rst_req_out, .pc_sp_rst_out);

//--- test_kwdt_top.sv
`timescale 1ns/1ps
module test_kwdt_top
  import kwdt_pkg::*;
;
  localparam logic [3:0] ctl = KWDT_CTRL_OFS;
  localparam logic [3:0] flg = KWDT_FLAG_OFS;
  logic ref_clk_in, sys_rst_in, watchdog_clear_instr_in, halt_in, sleep_in;
  logic [KWDT_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic sys_rst_req_out, pc_sp_rst_out, irq_out;
  int fail_count, samples_checked, n;
  kwdt_top u_kwdt_top (.ref_clk_in, .sys_rst_in, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .watchdog_clear_instr_in, .halt_in, .sleep_in, .sys_rst_req_out, .pc_sp_rst_out,
    .irq_out);
  initial
  begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // bus tasks start just after a rising edge; handshakes judged at negedge
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
    input logic [1:0] er = KWDT_RESP_OK);
    logic ta, tw, tb;
    tb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb)
    begin
      @(negedge ref_clk_in);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      if (tb)
        chk({30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge ref_clk_in);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e,
    input logic [1:0] er = KWDT_RESP_OK);
    logic ta, tr;
    tr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr)
    begin
      @(negedge ref_clk_in);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      if (tr)
      begin
        chk(s_axi_rdata, {24'h0, e});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
      @(posedge ref_clk_in);
      if (ta)
        s_axi_arvalid <= 1'b0;
    end
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(negedge ref_clk_in);
    chk({31'h0, irq_out}, {31'h0, e});
    @(posedge ref_clk_in);
  endtask
  initial
  begin
    #800000;
    fail_count++;
    end_sim;
  end
  initial
  begin
    {sys_rst_in, watchdog_clear_instr_in, halt_in, sleep_in} = 4'h8;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    fail_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    rd(ctl, KWDT_CTRL_RST);
    rd(flg, 8'h00);
    rd(4'h2, 8'h00, KWDT_RESP_ERR);
    wr(4'h2, 8'h00, KWDT_RESP_ERR);
    for (int s = 0; s < 8; s++)
    begin
      wr(ctl, {KWDT_KEY_EN, 3'(s)});
      rd(ctl, {KWDT_KEY_EN, 3'(s)});
    end
    wr(ctl, {KWDT_KEY_DIS, 3'h3});
    rd(ctl, {KWDT_KEY_DIS, 3'h3});
    halt_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    halt_in <= 1'b0;
    rd(flg, 8'h04);
    watchdog_clear_instr_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    watchdog_clear_instr_in <= 1'b0;
    rd(flg, 8'h00);
    wr(ctl, 8'h00);
    n = 0;
    // pulse follows the bad key by the delay, give or take one tick
    do
    begin
      @(negedge ref_clk_in);
      n++;
    end
    while (sys_rst_req_out !== 1'b1 && n < 10 * KWDT_LSO_DIV);
    chk({31'h0, n > (KWDT_SRST_LSO - 1) * KWDT_LSO_DIV}, 32'h1);
    chk({31'h0, n < (KWDT_SRST_LSO + 1) * KWDT_LSO_DIV}, 32'h1);
    @(posedge ref_clk_in);
    rd(flg, 8'h01);
    rd(KWDT_IST_OFS, 8'h02);
    irq_is(1'b0);
    wr(KWDT_IMSK_OFS, 8'h02);
    irq_is(1'b1);
    wr(ctl, {KWDT_KEY_EN, 3'h3});
    wr(flg, 8'h01);
    rd(flg, 8'h01);
    wr(flg, 8'h00);
    rd(flg, 8'h00);
    wr(KWDT_IST_OFS, 8'h02);
    rd(KWDT_IST_OFS, 8'h00);
    irq_is(1'b0);
    end_sim;
  end
endmodule
